// >>> hdl/drp_ctl.sv
// controller end: APB registers, command timing guard and refresh credit
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
module drp_ctl import drp_pkg::*; #(
  parameter int REFI = REFI_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the device
  drp_link_if.ctl link
);
  typedef enum logic [1:0] {ST_IDLE, ST_WLAT, ST_WBEAT, ST_RD} drp_st_e;

  typedef struct packed {
    drp_st_e st;
    logic rdy;
    logic slverr;
    logic [31:0] rdat;
    logic pend;
    drp_op_e op;
    logic ap;
    logic chop;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] wdata;
    logic [MASK_W-1:0] wmask;
    logic [2:0] cfg;
    logic err;
    logic [DQ_W-1:0] rdata;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][CNT_W-1:0] hold;
    logic [NBANK-1:0][CNT_W-1:0] rc;
    logic [CNT_W-1:0] gap;
    logic [REFI_W-1:0] refi;
    logic signed [CRED_W-1:0] credit;
    logic [CNT_W-1:0] cnt;
    logic [3:0] beat;
    logic [3:0] len;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [ADDR_W-1:0] a;
    logic [BA_W-1:0] pba;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic [MASK_W-1:0] bmask;
    logic wstb;
  } drp_ctl_s;

  drp_ctl_s q;
  drp_ctl_s next_q;
  logic busy;
  logic hold_any;
  logic force_ref;
  logic [31:0] stat;
  drp_op_e issue;
  logic [ADDR_W-1:0] ia;

  assign busy = q.pend || (q.st != ST_IDLE);
  // a full credit of postponed refreshes overrides software
  assign force_ref = (q.credit >= CRED_HI); // RQ20
  assign stat = {{(16 - CRED_W){q.credit[CRED_W-1]}}, q.credit, q.open,
    6'h00, q.err, busy};

  always_comb begin
    next_q = q;
    issue = OP_NOP;
    ia = q.addr;
    hold_any = 1'b0;
    next_q.rdy = 1'b0;
    next_q.slverr = 1'b0;
    next_q.cs_n = 1'b1;
    for (int b = 0; b < NBANK; b++) begin
      hold_any = hold_any | (q.hold[b] != '0);
      if (q.hold[b] != '0) begin
        next_q.hold[b] = q.hold[b] - 1'b1;
      end
      if (q.rc[b] != '1) begin
        next_q.rc[b] = q.rc[b] + 1'b1;
      end
    end
    if (q.gap != '0) begin
      next_q.gap = q.gap - 1'b1;
    end
    // one credit per average period; frozen while the device sleeps
    if (q.refi == REFI_W'(REFI - 1)) begin
      next_q.refi = '0;
      if (!q.cfg[CFG_FREEZE_BIT]) begin // RQ22
        next_q.credit = q.credit + 6'sh01; // RQ19 RQ24
      end
    end else begin
      next_q.refi = q.refi + 1'b1;
    end
    // one wait state: pready rises in the second access cycle
    if (psel && penable && !q.rdy) begin
      next_q.rdy = 1'b1;
      next_q.rdat = '0;
      case (paddr)
        REG_CMD: begin
          if (pwrite && !busy) begin
            next_q.pend = 1'b1;
            next_q.op = drp_op_e'(pwdata[CMD_OP_LSB +: 3]);
            next_q.ap = pwdata[CMD_AP_BIT];
            next_q.chop = pwdata[CMD_CHOP_BIT];
            next_q.ba = pwdata[CMD_BANK_LSB +: BA_W];
          end
        end
        REG_ADDR: begin
          if (pwrite) next_q.addr = pwdata[ADDR_W-1:0];
          else next_q.rdat = 32'(q.addr);
        end
        REG_WDATA: begin
          if (pwrite) {next_q.wmask, next_q.wdata} =
            pwdata[MASK_W+DQ_W-1:0];
          else next_q.rdat = 32'({q.wmask, q.wdata});
        end
        REG_STAT: begin
          if (pwrite && pwdata[STAT_ERR_BIT]) next_q.err = 1'b0;
          else if (!pwrite) next_q.rdat = stat;
        end
        REG_RDATA: begin
          if (!pwrite) next_q.rdat = 32'(q.rdata);
        end
        REG_CFG: begin
          if (pwrite) next_q.cfg = pwdata[2:0];
          else next_q.rdat = 32'(q.cfg);
        end
        default: next_q.slverr = 1'b1;
      endcase
    end
    unique case (q.st)
      ST_IDLE: begin
        if (q.gap == '0) begin // RQ18
          if (force_ref || (!q.pend && q.cfg[CFG_AUTO_BIT] &&
              q.credit > 6'sh00)) begin
            if (q.open == '0 && !hold_any) issue = OP_REF; // RQ15
            else if (q.open != '0) begin
              issue = OP_PRE;
              ia[AP_BIT] = 1'b1;
            end
          end else if (q.pend) begin
            next_q.pend = 1'b0;
            case (q.op)
              OP_ACT: begin
                if (q.open[q.ba]) next_q.err = 1'b1;
                else if (q.hold[q.ba] == '0 &&
                    q.rc[q.ba] >= CNT_W'(RC_CYC)) begin // RQ12 RQ13
                  issue = OP_ACT;
                  next_q.open[q.ba] = 1'b1;
                  next_q.rc[q.ba] = '0;
                end else next_q.pend = 1'b1;
              end
              OP_RD, OP_WR: begin
                if (!q.open[q.ba]) next_q.err = 1'b1;
                else begin
                  issue = q.op;
                  ia[AP_BIT] = q.ap;
                  ia[BURST_BIT] = !q.chop;
                  next_q.len = (q.cfg[CFG_OTF_BIT] && q.chop) ?
                    4'(BURST_CHOP) : 4'(BURST_LONG);
                  next_q.beat = '0;
                  next_q.cnt = CNT_W'(WL_CYC - 1);
                  next_q.st = (q.op == OP_RD) ? ST_RD : ST_WLAT;
                  if (q.ap) begin
                    next_q.open[q.ba] = 1'b0;
                    // read: worst case close start plus close time
                    next_q.hold[q.ba] = (q.op == OP_RD) ?
                      CNT_W'(ADD_LAT_CYC + RTP_CYC + RAS_CYC + RP_CYC) :
                      '1; // RQ12
                  end
                end
              end
              OP_PRE: begin
                issue = OP_PRE;
                ia[AP_BIT] = q.ap;
              end
              OP_REF: begin
                // pulled-in refreshes beyond the limit earn nothing
                if (q.credit <= CRED_LO) next_q.err = 1'b1; // RQ21
                else if (q.open == '0 && !hold_any) issue = OP_REF;
                else next_q.pend = 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
      end
      ST_WLAT: begin
        if (q.cnt != '0) next_q.cnt = q.cnt - 1'b1;
        else begin
          next_q.dq_o = q.wdata;
          next_q.dq_oe = 1'b1;
          next_q.bmask = q.wmask;
          next_q.wstb = 1'b1;
          next_q.st = ST_WBEAT;
        end
      end
      ST_WBEAT: begin
        if (q.beat == q.len - 1'b1) begin
          next_q.dq_oe = 1'b0;
          next_q.wstb = 1'b0;
          next_q.st = ST_IDLE;
          if (q.ap) begin
            next_q.hold[q.ba] = CNT_W'(WR_CYC + RP_CYC + 1); // RQ13
          end
        end else next_q.beat = q.beat + 1'b1;
      end
      ST_RD: begin
        if (link.rstb) begin
          next_q.rdata = link.dq_i;
          next_q.beat = q.beat + 1'b1;
          if (q.beat == q.len - 1'b1) next_q.st = ST_IDLE;
        end
      end
    endcase
    if (issue == OP_PRE) begin
      for (int b = 0; b < NBANK; b++) begin
        if (q.open[b] && (ia[AP_BIT] || b == int'(q.ba))) begin
          next_q.open[b] = 1'b0;
          next_q.hold[b] = CNT_W'(RP_CYC);
        end
      end
    end
    if (issue == OP_REF) begin
      next_q.gap = CNT_W'(RFC_CYC);
      next_q.credit = next_q.credit - 6'sh01; // RQ24
    end
    if (issue != OP_NOP) begin
      next_q.cs_n = 1'b0;
      next_q.a = ia;
      next_q.pba = q.ba;
      unique case (issue)
        OP_ACT: {next_q.ras_n, next_q.cas_n, next_q.we_n} = 3'h3;
        OP_RD: {next_q.ras_n, next_q.cas_n, next_q.we_n} = 3'h5;
        OP_WR: {next_q.ras_n, next_q.cas_n, next_q.we_n} = 3'h4;
        OP_PRE: {next_q.ras_n, next_q.cas_n, next_q.we_n} = 3'h2;
        default: {next_q.ras_n, next_q.cas_n, next_q.we_n} = 3'h1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.ras_n <= 1'b1;
      q.cas_n <= 1'b1;
      q.we_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.rdat;
  assign pready = q.rdy;
  assign pslverr = q.slverr;
  assign link.cs_n = q.cs_n;
  assign link.ras_n = q.ras_n;
  assign link.cas_n = q.cas_n;
  assign link.we_n = q.we_n;
  assign link.a = q.a;
  assign link.ba = q.pba;
  assign link.ctl_dq_o = q.dq_o;
  assign link.ctl_dq_oe = q.dq_oe;
  assign link.write_byte_mask = q.bmask;
  assign link.wstb = q.wstb;
endmodule

// >>> hdl/drp_dev.sv
// device end: bank closing, auto close, refresh and masked write storage
//
// Overview of operation
// [RQ1] bad data timing corrupts only addressed location
// [RQ2] bad strobe timing corrupts only addressed location
// [RQ3] one mask bit per eight data lines
// [RQ4] mask sampled like data, ignored on reads
// [RQ5] decode precharge: cs, ras, we low
// [RQ6] single-bank precharge uses three bank bits
// [RQ7] all-banks bit closes all eight banks
// [RQ8] auto-close bit chooses open or closed
// [RQ9] read auto close after latency plus read delay
// [RQ10] write auto close after data plus recovery
// [RQ11] auto close waits for row active time
// [RQ12] controller waits close and row cycle after read
// [RQ13] controller waits recovery, close and row cycle
// [RQ14] decode refresh: cs, ras, cas low
// [RQ15] controller refreshes only with banks idle
// [RQ16] refresh row from internal counter only
// [RQ17] refresh ends with all banks closed
// [RQ18] controller idles for refresh cycle time
// [RQ19] controller repeats refresh each average period
// [RQ20] at most eight refreshes postponed
// [RQ21] at most eight pulled in, credit capped
// [RQ22] postponed count frozen during self refresh
// [RQ23] address bit 12 picks four or eight beats
// [RQ24] controller keeps signed refresh credit counter
`timescale 1ns/100ps
module drp_dev import drp_pkg::*; #(
  parameter int ROW_W = 14
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to the controller
  drp_link_if.dev link,
  // user side
  input wire logic otf_en,
  output logic [NBANK-1:0] bank_open,
  output logic [ROW_W-1:0] refresh_row,
  output logic refresh_busy
);
  localparam int MEM_W = NBANK << COL_W;
  localparam int IDX_W = BA_W + COL_W;

  typedef struct packed {
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][CNT_W-1:0] ras;
    logic [NBANK-1:0] ap;
    logic [NBANK-1:0][CNT_W-1:0] apc;
    logic [ROW_W-1:0] row;
    logic [CNT_W-1:0] rfc;
    logic rbusy;
    logic wr_act;
    logic [CNT_W-1:0] wr_lat;
    logic [3:0] wr_beat;
    logic [3:0] wr_len;
    logic [BA_W-1:0] wr_ba;
    logic [COL_W-1:0] wr_col;
    logic wr_ap;
    logic rd_act;
    logic [CNT_W-1:0] rd_lat;
    logic [3:0] rd_beat;
    logic [3:0] rd_len;
    logic [BA_W-1:0] rd_ba;
    logic [COL_W-1:0] rd_col;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic rstb;
    logic [MEM_W-1:0][DQ_W-1:0] mem;
  } drp_dev_s;

  drp_dev_s q;
  drp_dev_s next_q;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic [3:0] cmd_len;

  // beats wrap inside an aligned block of eight columns
  assign wr_idx = {q.wr_ba, q.wr_col[COL_W-1:3],
    3'(q.wr_col[2:0] + q.wr_beat[2:0])};
  assign rd_idx = {q.rd_ba, q.rd_col[COL_W-1:3],
    3'(q.rd_col[2:0] + q.rd_beat[2:0])};
  // with on-the-fly off every burst is eight beats long
  assign cmd_len = (otf_en && !link.a[BURST_BIT]) ? 4'(BURST_CHOP) :
    4'(BURST_LONG); // RQ23

  always_comb begin
    next_q = q;
    next_q.dq_oe = 1'b0;
    next_q.rstb = 1'b0;
    for (int b = 0; b < NBANK; b++) begin
      if (q.ras[b] != '1) begin
        next_q.ras[b] = q.ras[b] + 1'b1;
      end
      if (q.ap[b]) begin
        if (q.apc[b] != '0) begin
          next_q.apc[b] = q.apc[b] - 1'b1;
        end else if (q.ras[b] >= CNT_W'(RAS_CYC)) begin // RQ9 RQ11
          next_q.ap[b] = 1'b0;
          next_q.open[b] = 1'b0;
        end
      end
    end
    // write burst: the beat count advances whether or not the strobe
    // came, so a bad strobe costs only this location and never hangs
    if (q.wr_act) begin
      if (q.wr_lat != '0) begin
        next_q.wr_lat = q.wr_lat - 1'b1;
      end else begin
        if (link.wstb) begin // RQ1 RQ2
          for (int l = 0; l < MASK_W; l++) begin
            if (!link.write_byte_mask[l]) begin // RQ3 RQ4
              next_q.mem[wr_idx][l*8 +: 8] = link.dq_i[l*8 +: 8];
            end
          end
        end
        next_q.wr_beat = q.wr_beat + 1'b1;
        if (q.wr_beat == q.wr_len - 1'b1) begin
          next_q.wr_act = 1'b0;
          if (q.wr_ap) begin // RQ10
            next_q.ap[q.wr_ba] = 1'b1;
            next_q.apc[q.wr_ba] = CNT_W'(WR_CYC);
          end
        end
      end
    end
    // read burst: the mask input is never looked at here
    if (q.rd_act) begin
      if (q.rd_lat != '0) begin
        next_q.rd_lat = q.rd_lat - 1'b1;
      end else begin
        next_q.dq_o = q.mem[rd_idx];
        next_q.dq_oe = 1'b1;
        next_q.rstb = 1'b1;
        next_q.rd_beat = q.rd_beat + 1'b1;
        if (q.rd_beat == q.rd_len - 1'b1) begin
          next_q.rd_act = 1'b0;
        end
      end
    end
    if (q.rfc != '0) begin
      next_q.rfc = q.rfc - 1'b1;
      if (q.rfc == CNT_W'(1)) begin
        next_q.open = '0; // RQ17
        next_q.ap = '0;
      end
    end
    if (!link.cs_n) begin
      case ({link.ras_n, link.cas_n, link.we_n})
        3'b011: begin
          next_q.open[link.ba] = 1'b1;
          next_q.ras[link.ba] = '0;
        end
        3'b010: begin // RQ5
          if (link.a[AP_BIT]) begin
            next_q.open = '0; // RQ7
            next_q.ap = '0;
          end else begin
            next_q.open[link.ba] = 1'b0; // RQ6
            next_q.ap[link.ba] = 1'b0;
          end
        end
        3'b101: begin
          next_q.rd_act = 1'b1;
          next_q.rd_lat = CNT_W'(RL_CYC - 1);
          next_q.rd_beat = '0;
          next_q.rd_len = cmd_len;
          next_q.rd_ba = link.ba;
          next_q.rd_col = link.a[COL_W-1:0];
          if (link.a[AP_BIT]) begin // RQ8
            next_q.ap[link.ba] = 1'b1;
            // the count is looked at one cycle after loading
            next_q.apc[link.ba] = CNT_W'(ADD_LAT_CYC + RTP_CYC - 1); // RQ9
          end
        end
        3'b100: begin
          next_q.wr_act = 1'b1;
          next_q.wr_lat = CNT_W'(WL_CYC - 1);
          next_q.wr_beat = '0;
          next_q.wr_len = cmd_len;
          next_q.wr_ba = link.ba;
          next_q.wr_col = link.a[COL_W-1:0];
          next_q.wr_ap = link.a[AP_BIT]; // RQ8
        end
        3'b001: begin // RQ14
          // the address bus is not looked at for a refresh
          next_q.row = q.row + 1'b1; // RQ16
          next_q.rfc = CNT_W'(RFC_CYC);
        end
        default: begin
        end
      endcase
    end
    next_q.rbusy = (next_q.rfc != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.dev_dq_o = q.dq_o;
  assign link.dev_dq_oe = q.dq_oe;
  assign link.rstb = q.rstb;
  assign bank_open = q.open;
  assign refresh_row = q.row;
  assign refresh_busy = q.rbusy;
endmodule

// >>> inc/drp_link_if.sv
// interface: command, address, data and strobe link between the two ends
`timescale 1ns/100ps
interface drp_link_if import drp_pkg::*; ();
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [ADDR_W-1:0] a;
  logic [BA_W-1:0] ba;
  logic [DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [DQ_W-1:0] dq_i;
  logic [MASK_W-1:0] write_byte_mask;
  logic wstb;
  logic rstb;
  // shared data wire: the driving end wins, the device end if both drive
  assign dq_i = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  modport dev (input cs_n, ras_n, cas_n, we_n, a, ba, dq_i,
    write_byte_mask, wstb, output dev_dq_o, dev_dq_oe, rstb);
  modport ctl (output cs_n, ras_n, cas_n, we_n, a, ba, ctl_dq_o,
    ctl_dq_oe, write_byte_mask, wstb, input dq_i, rstb);
endinterface

// >>> inc/drp_pkg.sv
// package: constants and types shared by the controller and device ends
package drp_pkg;
  localparam int NBANK = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int DQ_W = 16;
  localparam int MASK_W = DQ_W / 8;
  localparam int COL_W = 4;
  localparam int CNT_W = 8;
  localparam int REFI_W = 16;
  localparam int CRED_W = 6;
  localparam int AP_BIT = 10;
  localparam int BURST_BIT = 12;
  localparam int BURST_LONG = 8;
  localparam int BURST_CHOP = 4;
  // times in picoseconds, clock 10 MHz
  localparam int CLK_PS = 100000;
  localparam int T_RP_PS = 13750;
  localparam int T_RAS_PS = 35000;
  localparam int T_WR_PS = 15000;
  localparam int T_RTP_PS = 7500;
  localparam int T_RC_PS = 48750;
  localparam int T_RFC_PS = 110000;
  localparam int T_REFI_PS = 7800000;
  function automatic int cyc_min(int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RP_CYC = cyc_min(T_RP_PS);
  localparam int RAS_CYC = cyc_min(T_RAS_PS);
  localparam int WR_CYC = cyc_min(T_WR_PS);
  localparam int RTP_CYC = cyc_min(T_RTP_PS);
  localparam int RC_CYC = cyc_min(T_RC_PS);
  localparam int RFC_CYC = cyc_min(T_RFC_PS);
  // average interval, so rounded down
  localparam int REFI_CYC = T_REFI_PS / CLK_PS;
  localparam int ADD_LAT_CYC = 0;
  localparam int WL_CYC = 5;
  localparam int RL_CYC = 5;
  localparam int POSTPONE_MAX = 8;
  localparam int PULLIN_MAX = 8;
  localparam logic signed [CRED_W-1:0] CRED_HI = CRED_W'(POSTPONE_MAX);
  localparam logic signed [CRED_W-1:0] CRED_LO = CRED_W'(-PULLIN_MAX);
  // controller register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_CFG = 8'h14;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_AP_BIT = 4;
  localparam int CMD_CHOP_BIT = 5;
  localparam int CMD_BANK_LSB = 8;
  localparam int CFG_OTF_BIT = 0;
  localparam int CFG_AUTO_BIT = 1;
  localparam int CFG_FREEZE_BIT = 2;
  localparam int STAT_ERR_BIT = 1;
  typedef enum logic [2:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF
  } drp_op_e;
endpackage

// >>> tb/drp_bench.sv
// testbench: both ends joined, driven over apb register accesses
`timescale 1ns/100ps
module drp_bench import drp_pkg::*; ();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic otf_en = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NBANK-1:0] bank_open;
  logic [13:0] refresh_row;
  logic refresh_busy;
  logic [31:0] rdv;
  logic errv;
  int fail_count = 0;
  int total_checks = 0;
  always #50 pclk = ~pclk;
  drp_link_if lnk();
  drp_dev u_drp_dev (.pclk(pclk), .presetn(presetn), .link(lnk),
    .otf_en(otf_en), .bank_open(bank_open), .refresh_row(refresh_row),
    .refresh_busy(refresh_busy));
  // short refresh period keeps credit runs brief
  drp_ctl #(.REFI(20)) u_drp_ctl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(lnk));
  drp_props u_drp_props (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n),
    .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .a(lnk.a),
    .ba(lnk.ba), .ctl_dq_oe(lnk.ctl_dq_oe), .dev_dq_oe(lnk.dev_dq_oe),
    .wstb(lnk.wstb), .rstb(lnk.rstb), .bank_open(bank_open),
    .refresh_row(refresh_row), .refresh_busy(refresh_busy));
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] ad, input logic w,
                      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // command writes are dropped while busy, so wait for it to clear
  task automatic cmd(input drp_op_e op, input logic ap, input logic chop,
                     input int bank);
    xfer(REG_CMD, 1'b1, 32'(op) | (32'(ap) << CMD_AP_BIT)
      | (32'(chop) << CMD_CHOP_BIT) | (32'(bank) << CMD_BANK_LSB));
    do begin
      xfer(REG_STAT, 1'b0, 32'h0);
    end while (rdv[0] !== 1'b0);
  endtask
  task automatic stat(input string what, input logic [7:0] open);
    xfer(REG_STAT, 1'b0, 32'h0);
    chk(what, {24'h0, open}, {24'h0, rdv[15:8]});
    chk("device banks", {24'h0, open}, {24'h0, bank_open});
  endtask
  task automatic rdback(input string what, input logic [15:0] exp);
    xfer(REG_RDATA, 1'b0, 32'h0);
    chk(what, {16'h0, exp}, rdv);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    logic [7:0] open;
    logic [13:0] row0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // freeze credit so pull-in counts are exact
    xfer(REG_CFG, 1'b1, 32'h4);
    xfer(REG_STAT, 1'b0, 32'h0);
    chk("status after reset", 32'h0, rdv);
    xfer(REG_ADDR, 1'b1, 32'h0);
    cmd(OP_ACT, 1'b0, 1'b0, 2);
    xfer(REG_WDATA, 1'b1, 32'h0001beef);
    cmd(OP_WR, 1'b0, 1'b0, 2);
    xfer(REG_WDATA, 1'b1, 32'h00030000);
    cmd(OP_RD, 1'b0, 1'b0, 2);
    rdback("masked lane", 16'hbe00);
    stat("open after plain read", 8'h04);
    $display("test mask done");
    xfer(REG_CFG, 1'b1, 32'h5);
    otf_en <= 1'b1;
    xfer(REG_WDATA, 1'b1, 32'h00005555);
    cmd(OP_WR, 1'b0, 1'b1, 2);
    cmd(OP_RD, 1'b0, 1'b0, 2);
    rdback("column past chopped write", 16'hbe00);
    cmd(OP_RD, 1'b0, 1'b1, 2);
    rdback("chopped read", 16'h5555);
    $display("test burst select done");
    cmd(OP_RD, 1'b1, 1'b0, 2);
    stat("read auto close", 8'h00);
    cmd(OP_ACT, 1'b0, 1'b0, 3);
    cmd(OP_WR, 1'b1, 1'b0, 3);
    stat("write auto close", 8'h00);
    cmd(OP_ACT, 1'b0, 1'b0, 3);
    xfer(REG_STAT, 1'b0, 32'h0);
    chk("reopen", 32'h0800, {16'h0, rdv[15:0]});
    $display("test auto close done");
    for (int b = 0; b < NBANK; b++) begin
      if (b != 3) cmd(OP_ACT, 1'b0, 1'b0, b);
    end
    open = 8'hff;
    for (int b = 0; b < NBANK; b++) begin
      cmd(OP_PRE, 1'b0, 1'b0, b);
      open[b] = 1'b0;
      stat("single bank precharge", open);
    end
    cmd(OP_ACT, 1'b0, 1'b0, 1);
    cmd(OP_ACT, 1'b0, 1'b0, 5);
    cmd(OP_PRE, 1'b1, 1'b0, 6);
    stat("all banks precharge", 8'h00);
    $display("test precharge done");
    row0 = refresh_row;
    repeat (9) cmd(OP_REF, 1'b0, 1'b0, 0);
    chk("rows", {18'h0, row0 + 14'd8}, {18'h0, refresh_row});
    xfer(REG_STAT, 1'b0, 32'h0);
    chk("pull in limit", 32'hfff80002, rdv);
    xfer(REG_STAT, 1'b1, 32'h2);
    repeat (60) @(posedge pclk);
    xfer(REG_STAT, 1'b0, 32'h0);
    chk("frozen credit", 32'hfff80000, rdv);
    xfer(8'h20, 1'b1, 32'h1);
    chk("unmapped access", 32'h1, {31'h0, errv});
    $display("test refresh done");
    cmd(OP_ACT, 1'b0, 1'b0, 4);
    // credit climbs from -8 until a full postpone count forces refresh
    xfer(REG_CFG, 1'b1, 32'h1);
    repeat (400) @(posedge pclk);
    xfer(REG_CFG, 1'b1, 32'h5);
    xfer(REG_STAT, 1'b0, 32'h0);
    chk("forced credit", 32'h00070000, rdv);
    row0 = refresh_row;
    // auto refresh spends the remaining credit while frozen
    xfer(REG_CFG, 1'b1, 32'h7);
    repeat (60) @(posedge pclk);
    xfer(REG_STAT, 1'b0, 32'h0);
    chk("auto refresh drain", 32'h0, rdv);
    chk("auto rows", {18'h0, row0 + 14'd7}, {18'h0, refresh_row});
    $display("test credit done");
    report_and_stop();
  end
  // whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("FAIL watchdog expected done seen hang");
    report_and_stop();
  end
endmodule

// >>> tb/drp_props.sv
// checker: link command decode and device bank, refresh and strobe timing
`timescale 1ns/100ps
module drp_props import drp_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] a,
  input wire logic [BA_W-1:0] ba,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic wstb,
  input wire logic rstb,
  // device state
  input wire logic [NBANK-1:0] bank_open,
  input wire logic [13:0] refresh_row,
  input wire logic refresh_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic is_pre;
  logic is_ref;
  logic is_rd;
  logic is_wr;
  logic [BA_W-1:0] cmd_ba;
  assign is_pre = !cs_n && !ras_n && cas_n && !we_n;
  assign is_ref = !cs_n && !ras_n && !cas_n && we_n;
  assign is_rd = !cs_n && ras_n && !cas_n && we_n;
  assign is_wr = !cs_n && ras_n && !cas_n && !we_n;
  // bank of the last command, so burst-long checks keep the right bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_ba <= '0;
    else if (!cs_n) cmd_ba <= ba;
  end
  AST_PRE_ONE: assert property (is_pre && !a[AP_BIT]
    |=> !bank_open[$past(ba)]) else $error("bank open after precharge");
  AST_PRE_ALL: assert property (is_pre && a[AP_BIT]
    |=> bank_open == '0) else $error("banks open after precharge all");
  AST_REF_CLOSE: assert property (is_ref
    |=> bank_open == '0 && refresh_busy) else $error("refresh left a bank");
  AST_REF_BUSY: assert property ($rose(refresh_busy)
    |=> refresh_busy ##1 !refresh_busy) else $error("refresh busy length");
  AST_REF_ROW: assert property (is_ref
    |=> refresh_row == $past(refresh_row) + 14'h1)
    else $error("refresh row not advanced");
  AST_WSTB_DATA: assert property (wstb
    |-> ctl_dq_oe && !dev_dq_oe) else $error("write beat without data");
  AST_RD_DRIVE: assert property (rstb
    |-> dev_dq_oe && !ctl_dq_oe) else $error("read beat not driven");
  AST_RD_OPEN: assert property (is_rd && !a[AP_BIT]
    |=> bank_open[cmd_ba] [*4]) else $error("plain read closed bank");
  AST_RD_AP: assert property (is_rd && a[AP_BIT]
    |-> ##[1:6] !bank_open[cmd_ba]) else $error("read auto close late");
  AST_WR_AP: assert property (is_wr && a[AP_BIT]
    |=> bank_open[cmd_ba] [*8]) else $error("write auto close early");
  cover property (is_ref);
  cover property (is_pre && a[AP_BIT]);
  cover property (wstb);
  cover property (rstb);
endmodule
